/* File: core/bst_pkg.sv */
// Constants, opcodes and controller state codes for the boundary scan block.
// Assumes a single reference clock that oversamples the scan port pins.
package bst_pkg;

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   localparam int         IR_W       = 4;
   localparam logic [3:0] OP_EXTEST  = 4'h0;
   localparam logic [3:0] OP_SAMPLE  = 4'h1;
   localparam logic [3:0] OP_IDCODE  = 4'h2;
   localparam logic [3:0] OP_BYPASS  = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // ----------------------------------------------------------------
   // Identification word layout
   // ----------------------------------------------------------------
   localparam int ID_W        = 32;
   localparam int ID_MFR_LSB  = 1;
   localparam int ID_PART_LSB = 12;
   localparam int ID_VER_LSB  = 28;

   // ----------------------------------------------------------------
   // Pin sampling and chain geometry
   // ----------------------------------------------------------------
   localparam int         PIN_W         = 4;
   localparam int         PIN_TCK       = 0;
   localparam int         PIN_TMS       = 1;
   localparam int         PIN_TDI       = 2;
   localparam int         PIN_TRST      = 3;
   localparam logic [3:0] PIN_RST_VAL   = 4'h8;
   localparam logic [2:0] TLR_TMS_EDGES = 3'h5;
   localparam int         CELLS_PER_IO  = 3;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_EX2_DR = 4'h0, ST_EX1_DR = 4'h1, ST_SH_DR  = 4'h2, ST_PA_DR  = 4'h3,
      ST_SEL_IR = 4'h4, ST_UP_DR  = 4'h5, ST_CAP_DR = 4'h6, ST_SEL_DR = 4'h7,
      ST_EX2_IR = 4'h8, ST_EX1_IR = 4'h9, ST_SH_IR  = 4'ha, ST_PA_IR  = 4'hb,
      ST_RTI    = 4'hc, ST_UP_IR  = 4'hd, ST_CAP_IR = 4'he, ST_TLR    = 4'hf
   } bst_state_e;

endpackage

/* File: core/bst_chain_if.sv */
// Control and serial path between the port controller and the boundary chain.
// Assumes both ends run on the reference clock; strobes are one cycle wide.
`timescale 1ns/1ns
interface bst_chain_if;
   logic capture;
   logic shift;
   logic update;
   logic extest;
   logic tdi;
   logic sdo;

   modport ctrl  (output capture, output shift, output update, output extest,
                  output tdi, input sdo);
   modport chain (input capture, input shift, input update, input extest,
                  input tdi, output sdo);
endinterface

/* File: core/bst_bsr.sv */
// Boundary scan register: three cells per I/O (input, output data, enable).
// Assumes strobes from the port controller, each one reference cycle wide.
`timescale 1ns/1ns
module bst_bsr #(
   parameter int NUM_IO = 8
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   bst_chain_if.chain             chain,
   input  wire logic [NUM_IO-1:0] pin_in_i,
   input  wire logic [NUM_IO-1:0] core_out_i,
   input  wire logic [NUM_IO-1:0] core_oe_i,
   output logic      [NUM_IO-1:0] pin_out_o,
   output logic      [NUM_IO-1:0] pin_oe_o,
   output logic      [NUM_IO-1:0] core_in_o
);
   localparam int N = bst_pkg::CELLS_PER_IO * NUM_IO;

   typedef struct packed {
      logic [N-1:0] sh;
      logic [N-1:0] upd;
   } bst_bsr_s;

   bst_bsr_s     st_reg;
   bst_bsr_s     st_next;
   logic [N-1:0] cap_vec;

   if (NUM_IO < 1) begin : g_chk
      $error("bst_bsr: NUM_IO must be at least 1");
   end

   // ----------------------------------------------------------------
   // Per I/O parallel paths
   // ----------------------------------------------------------------
   for (genvar k = 0; k < NUM_IO; k++) begin : g_io
      assign cap_vec[3*k]   = pin_in_i[k];
      assign cap_vec[3*k+1] = core_out_i[k];
      assign cap_vec[3*k+2] = core_oe_i[k];
      assign pin_out_o[k]   = chain.extest ? st_reg.upd[3*k+1] : core_out_i[k];
      assign pin_oe_o[k]    = chain.extest ? st_reg.upd[3*k+2] : core_oe_i[k];
      assign core_in_o[k]   = pin_in_i[k];
   end

   // ----------------------------------------------------------------
   // Cell state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (chain.capture) begin
         st_next.sh = cap_vec;
      end else if (chain.shift) begin
         st_next.sh = {chain.tdi, st_reg.sh[N-1:1]};
      end
      if (chain.update) begin
         st_next.upd = st_reg.sh;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign chain.sdo = st_reg.sh[0];

   a_bsr_update : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      chain.update && !chain.capture && !chain.shift |=> st_reg.upd == $past(st_reg.sh))
      else $error("boundary update did not latch shift stage");
endmodule

/* File: core/bst_tap.sv */
// Boundary scan port controller with instruction, bypass and id registers.
// Assumes scan pins are asynchronous and much slower than ref_clk_i.
//
// Summary of operation
// - Standard test logic: port controller, instruction register, selectable data registers.
// - Data registers are bypass, identification and boundary scan only.
// - Bypass is selected whenever no other data register is addressed.
// - Identification register is a 32-bit shift register with four fields.
// - Boundary register observes and controls every I/O, three cells each.
// - Each cell has serial in/out and parallel in; only output data and enable cells have parallel out.
// - Controller is sixteen states in four bits, standard transition graph.
// - Apart from TRST, state moves only on rising TCK, following TMS sampled there.
// - IR states operate instruction register; DR states the selected register.
// - Only TMS, TCK and TRST steer; controller derives capture, shift, update strobes.
// - After power-up the controller sits in Test-Logic-Reset.
// - Five rising TCK edges with TMS high reach Test-Logic-Reset.
// - TRST low forces Test-Logic-Reset without waiting for TCK.
`timescale 1ns/1ns
module bst_tap #(
   parameter int          NUM_IO   = 8,
   parameter logic [10:0] MFR_ID   = 11'h0aa,    // Arbitrary value
   parameter logic [15:0] PART_NUM = 16'h1234,   // Arbitrary value
   parameter logic [3:0]  VERSION  = 4'h1        // Arbitrary value
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              tck_i,
   input  wire logic              tms_i,
   input  wire logic              tdi_i,
   input  wire logic              trst_b_i,
   output logic                   tdo_o,
   output logic                   tdo_oe_o,
   input  wire logic [NUM_IO-1:0] pin_in_i,
   input  wire logic [NUM_IO-1:0] core_out_i,
   input  wire logic [NUM_IO-1:0] core_oe_i,
   output logic      [NUM_IO-1:0] pin_out_o,
   output logic      [NUM_IO-1:0] pin_oe_o,
   output logic      [NUM_IO-1:0] core_in_o
);
   localparam logic [bst_pkg::ID_W-1:0] IDCODE_VAL = {VERSION, PART_NUM, MFR_ID, 1'b1};

   typedef struct packed {
      logic [bst_pkg::PIN_W-1:0] s1;
      logic [bst_pkg::PIN_W-1:0] s2;
      logic [bst_pkg::PIN_W-1:0] s3;
      logic [bst_pkg::PIN_W-1:0] flt;
      bst_pkg::bst_state_e       state;
      logic [bst_pkg::IR_W-1:0]  ir_sh;
      logic [bst_pkg::IR_W-1:0]  ir;
      logic                      byp;
      logic [bst_pkg::ID_W-1:0]  id_sh;
      logic                      tdo;
      logic                      tdo_oe;
   } bst_tap_s;

   bst_tap_s    st_reg;
   bst_tap_s    st_next;
   logic        tck_rise;
   logic        tck_fall;
   logic        trst_act;
   logic        tms;
   logic        sel_bsr;
   logic        sel_id;
   logic        dr_sdo;
   bst_chain_if chain_if ();

   // ----------------------------------------------------------------
   // Edge and level detection on the scan pins
   // ----------------------------------------------------------------
   assign tck_rise = (st_reg.s2[bst_pkg::PIN_TCK] == st_reg.s3[bst_pkg::PIN_TCK])
                   && st_reg.s3[bst_pkg::PIN_TCK] && !st_reg.flt[bst_pkg::PIN_TCK];
   assign tck_fall = (st_reg.s2[bst_pkg::PIN_TCK] == st_reg.s3[bst_pkg::PIN_TCK])
                   && !st_reg.s3[bst_pkg::PIN_TCK] && st_reg.flt[bst_pkg::PIN_TCK];
   assign trst_act = !st_reg.flt[bst_pkg::PIN_TRST];
   assign tms      = st_reg.flt[bst_pkg::PIN_TMS];

   // ----------------------------------------------------------------
   // Data register selection
   // ----------------------------------------------------------------
   assign sel_bsr = (st_reg.ir == bst_pkg::OP_EXTEST) || (st_reg.ir == bst_pkg::OP_SAMPLE);
   assign sel_id  = (st_reg.ir == bst_pkg::OP_IDCODE);
   assign dr_sdo  = sel_bsr ? chain_if.sdo : (sel_id ? st_reg.id_sh[0] : st_reg.byp);

   assign chain_if.capture = tck_rise && !trst_act && sel_bsr && st_reg.state == bst_pkg::ST_CAP_DR;
   assign chain_if.shift   = tck_rise && !trst_act && sel_bsr && st_reg.state == bst_pkg::ST_SH_DR;
   assign chain_if.update  = tck_rise && !trst_act && sel_bsr && st_reg.state == bst_pkg::ST_UP_DR;
   assign chain_if.extest  = st_reg.ir == bst_pkg::OP_EXTEST;
   assign chain_if.tdi     = st_reg.flt[bst_pkg::PIN_TDI];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = {trst_b_i, tdi_i, tms_i, tck_i};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int b = 0; b < bst_pkg::PIN_W; b++) begin
         if (st_reg.s2[b] == st_reg.s3[b]) begin
            st_next.flt[b] = st_reg.s3[b];
         end
      end
      if (trst_act) begin
         st_next.state = bst_pkg::ST_TLR;
      end else if (tck_rise) begin
         case (st_reg.state)
            bst_pkg::ST_TLR:    st_next.state = tms ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
            bst_pkg::ST_RTI:    st_next.state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_DR: st_next.state = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR: st_next.state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR:  st_next.state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR: st_next.state = tms ? bst_pkg::ST_UP_DR  : bst_pkg::ST_PA_DR;
            bst_pkg::ST_PA_DR:  st_next.state = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
            bst_pkg::ST_EX2_DR: st_next.state = tms ? bst_pkg::ST_UP_DR  : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UP_DR:  st_next.state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_IR: st_next.state = tms ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR: st_next.state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR:  st_next.state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR: st_next.state = tms ? bst_pkg::ST_UP_IR  : bst_pkg::ST_PA_IR;
            bst_pkg::ST_PA_IR:  st_next.state = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
            bst_pkg::ST_EX2_IR: st_next.state = tms ? bst_pkg::ST_UP_IR  : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UP_IR:  st_next.state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            default:            st_next.state = bst_pkg::ST_TLR;
         endcase
         case (st_reg.state)
            bst_pkg::ST_CAP_IR: st_next.ir_sh = bst_pkg::IR_CAPTURE;
            bst_pkg::ST_SH_IR:  st_next.ir_sh = {chain_if.tdi, st_reg.ir_sh[bst_pkg::IR_W-1:1]};
            bst_pkg::ST_UP_IR:  st_next.ir    = st_reg.ir_sh;
            bst_pkg::ST_CAP_DR: begin
               st_next.byp   = 1'b0;
               st_next.id_sh = IDCODE_VAL;
            end
            bst_pkg::ST_SH_DR: begin
               st_next.byp = chain_if.tdi;
               if (sel_id) begin
                  st_next.id_sh = {chain_if.tdi, st_reg.id_sh[bst_pkg::ID_W-1:1]};
               end
            end
            default: begin
            end
         endcase
      end
      if (st_reg.state == bst_pkg::ST_TLR) begin
         st_next.ir = bst_pkg::OP_IDCODE;
      end
      if (tck_fall) begin
         st_next.tdo    = (st_reg.state == bst_pkg::ST_SH_IR) ? st_reg.ir_sh[0] : dr_sdo;
         st_next.tdo_oe = (st_reg.state == bst_pkg::ST_SH_IR)
                        || (st_reg.state == bst_pkg::ST_SH_DR);
      end
      if (trst_act) begin
         st_next.tdo_oe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_reg        <= '0;
         st_reg.s1     <= bst_pkg::PIN_RST_VAL;
         st_reg.s2     <= bst_pkg::PIN_RST_VAL;
         st_reg.s3     <= bst_pkg::PIN_RST_VAL;
         st_reg.flt    <= bst_pkg::PIN_RST_VAL;
         st_reg.state  <= bst_pkg::ST_TLR;
         st_reg.ir     <= bst_pkg::OP_IDCODE;
         st_reg.id_sh  <= IDCODE_VAL;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tdo_o    = st_reg.tdo;
   assign tdo_oe_o = st_reg.tdo_oe;

   // ----------------------------------------------------------------
   // Boundary chain
   // ----------------------------------------------------------------
   bst_bsr #(.NUM_IO(NUM_IO)) u_bsr (
      .ref_clk_i  (ref_clk_i),
      .rst_b_i    (rst_b_i),
      .chain      (chain_if.chain),
      .pin_in_i   (pin_in_i),
      .core_out_i (core_out_i),
      .core_oe_i  (core_oe_i),
      .pin_out_o  (pin_out_o),
      .pin_oe_o   (pin_oe_o),
      .core_in_o  (core_in_o)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [2:0] tms_hi_cnt;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         tms_hi_cnt <= 3'h0;
      end else if (tck_rise) begin
         tms_hi_cnt <= !tms ? 3'h0 : (tms_hi_cnt == bst_pkg::TLR_TMS_EDGES ?
                       bst_pkg::TLR_TMS_EDGES : tms_hi_cnt + 3'h1);
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_five_tms_reset : assert property (tms_hi_cnt == bst_pkg::TLR_TMS_EDGES |->
      st_reg.state == bst_pkg::ST_TLR) else $error("five high TMS edges missed reset");
   a_trst_forces : assert property (trst_act |=> st_reg.state == bst_pkg::ST_TLR)
      else $error("TRST did not force reset state");
   a_state_on_rise : assert property (!tck_rise && !trst_act |=> $stable(st_reg.state))
      else $error("state moved without a rising TCK");
   a_tlr_idcode : assert property (st_reg.state == bst_pkg::ST_TLR |=>
      st_reg.ir == bst_pkg::OP_IDCODE) else $error("reset state did not select id");
   a_tdo_on_fall : assert property (!tck_fall |=> $stable(tdo_o))
      else $error("TDO changed off a falling TCK");
   a_tdo_oe_shift : assert property (tdo_oe_o |-> st_reg.state inside
      {bst_pkg::ST_SH_DR, bst_pkg::ST_SH_IR, bst_pkg::ST_EX1_DR, bst_pkg::ST_EX1_IR})
      else $error("TDO driven outside shift");
   a_ir_capture : assert property (tck_rise && !trst_act && st_reg.state == bst_pkg::ST_CAP_IR
      |=> st_reg.ir_sh == bst_pkg::IR_CAPTURE) else $error("IR capture value wrong");
   a_id_capture : assert property (tck_rise && !trst_act && st_reg.state == bst_pkg::ST_CAP_DR
      |=> st_reg.id_sh == IDCODE_VAL && st_reg.id_sh[0]) else $error("id capture wrong");
   a_bypass_path : assert property (tck_rise && !trst_act && st_reg.state == bst_pkg::ST_SH_DR
      |=> st_reg.byp == $past(chain_if.tdi)) else $error("bypass bit did not shift");

   c_five_tms : cover property (tms_hi_cnt == bst_pkg::TLR_TMS_EDGES);
   c_ir_update : cover property (tck_rise && st_reg.state == bst_pkg::ST_UP_IR);
   c_id_shift : cover property (sel_id && tdo_oe_o && st_reg.state == bst_pkg::ST_SH_DR);
   c_extest : cover property (chain_if.extest && chain_if.update);
endmodule

/* File: sim/bst_jtag_tester.sv */
// Scan port master model: drives TCK, TMS and TDI, samples TDO.
// Assumes a 320 ns TCK; TCK stands low between frames.
`timescale 1ns/1ns
module bst_jtag_tester (
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i
);
   logic tdo_wire;

   // Pull-up on the line while the device releases it
   assign tdo_wire = tdo_oe_i ? tdo_i : 1'b1;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // ----------------------------------------------------------------
   // One TCK period: fall, set TMS/TDI, rise, sample TDO late in high
   // ----------------------------------------------------------------
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tck_o <= 1'b0;
      tms_o <= tms;
      tdi_o <= tdi;
      #160;
      tck_o <= 1'b1;
      #150;
      tdo = tdo_wire;
      #10;
   endtask

   // From idle: select, capture, shift n bits LSB first, update, idle
   task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b0, b);
      if (is_ir) begin
         step(1'b1, 1'b0, b);
      end
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      tck_o <= 1'b0;
      tdi_o <= ~tdi_o;
      // Let the closing fall settle before any next frame drives the pins
      #40;
   endtask
endmodule

/* File: sim/boundary_scan_tap_test.sv */
// Self-checking bench for the boundary scan port controller.
// Assumes the tester model in bst_jtag_tester drives TCK, TMS and TDI; the bench drives TRST.
`timescale 1ns/1ns
module boundary_scan_tap_test;
   localparam int          NUM_IO = 4;
   localparam int          BSR_W  = 3 * NUM_IO;
   localparam logic [10:0] MFR    = 11'h155;   // Arbitrary value
   localparam logic [15:0] PART   = 16'h0c3a;  // Arbitrary value
   localparam logic [3:0]  VER    = 4'h6;      // Arbitrary value
   localparam logic [31:0] ID_EXP = {VER, PART, MFR, 1'b1};

   logic              ref_clk_i;
   logic              rst_b_i;
   logic              trst_b;
   logic              tck;
   logic              tms;
   logic              tdi;
   logic              tdo;
   logic              tdo_oe;
   logic [NUM_IO-1:0] pin_in;
   logic [NUM_IO-1:0] core_out;
   logic [NUM_IO-1:0] core_oe;
   logic [NUM_IO-1:0] pin_out;
   logic [NUM_IO-1:0] pin_oe;
   logic [NUM_IO-1:0] core_in;
   logic [63:0]       d;
   logic [63:0]       e;
   logic              b;
   int                error_cnt;
   int                total_checks;

   bst_tap #(.NUM_IO(NUM_IO), .MFR_ID(MFR), .PART_NUM(PART), .VERSION(VER)) u_dut (
      .ref_clk_i (ref_clk_i), .rst_b_i (rst_b_i), .tck_i (tck), .tms_i (tms),
      .tdi_i (tdi), .trst_b_i (trst_b), .tdo_o (tdo), .tdo_oe_o (tdo_oe),
      .pin_in_i (pin_in), .core_out_i (core_out), .core_oe_i (core_oe),
      .pin_out_o (pin_out), .pin_oe_o (pin_oe), .core_in_o (core_in));

   bst_jtag_tester u_tester (.tck_o (tck), .tms_o (tms), .tdi_o (tdi),
                             .tdo_i (tdo), .tdo_oe_i (tdo_oe));

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------------------------------
   // Comparison and verdict
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_id_after_reset();
      check(64'(tdo_oe), 64'h0);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.scan(1'b0, 32, 64'h0, d);
      check(64'(d[31:0]), 64'(ID_EXP));
   endtask

   task automatic t_bypass();
      logic [3:0] ops [2];
      ops[0] = bst_pkg::OP_BYPASS;
      ops[1] = 4'h9;
      foreach (ops[i]) begin
         u_tester.scan(1'b1, bst_pkg::IR_W, 64'(ops[i]), d);
         check(64'(d[3:0]), 64'(bst_pkg::IR_CAPTURE));
         u_tester.scan(1'b0, 8, 64'h5b, d);
         check(64'(d[7:0]), 64'h0b6);
      end
   endtask

   task automatic t_pause();
      u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b1, 1'b1, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      check(64'({tdo_oe, b}), 64'h1);
      u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.scan(1'b0, 32, 64'h0, d);
      check(64'(d[31:0]), 64'(ID_EXP));
   endtask

   task automatic t_sample();
      @(posedge ref_clk_i);
      pin_in   <= 4'ha;
      core_out <= 4'h6;
      core_oe  <= 4'hc;
      u_tester.scan(1'b1, bst_pkg::IR_W, 64'(bst_pkg::OP_SAMPLE), d);
      u_tester.scan(1'b0, BSR_W, 64'h0, d);
      e = '0;
      for (int k = 0; k < NUM_IO; k++) begin
         e[3*k]   = pin_in[k];
         e[3*k+1] = core_out[k];
         e[3*k+2] = core_oe[k];
      end
      check(d, e);
      check(64'({pin_out, pin_oe, core_in}), 64'({core_out, core_oe, pin_in}));
   endtask

   task automatic t_extest();
      u_tester.scan(1'b1, bst_pkg::IR_W, 64'(bst_pkg::OP_EXTEST), d);
      u_tester.scan(1'b0, BSR_W, 64'h9c5, d);
      repeat (6) @(posedge ref_clk_i);
      e = '0;
      for (int k = 0; k < NUM_IO; k++) begin
         e[k]          = 1'(12'h9c5 >> (3*k+1));
         e[NUM_IO + k] = 1'(12'h9c5 >> (3*k+2));
      end
      check(64'({pin_oe, pin_out}), e);
      check(64'(core_in), 64'(pin_in));
   endtask

   task automatic t_tms_reset();
      u_tester.step(1'b1, 1'b0, b);
      repeat (5) u_tester.step(1'b0, 1'b1, b);
      repeat (5) u_tester.step(1'b1, 1'b0, b);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.tck_o <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      check(64'(tdo_oe), 64'h0);
      check(64'({pin_out, pin_oe}), 64'({core_out, core_oe}));
      u_tester.scan(1'b0, 32, 64'h0, d);
      check(64'(d[31:0]), 64'(ID_EXP));
   endtask

   task automatic t_trst();
      u_tester.scan(1'b1, bst_pkg::IR_W, 64'(bst_pkg::OP_BYPASS), d);
      @(posedge ref_clk_i);
      trst_b <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      trst_b <= 1'b1;
      repeat (6) @(posedge ref_clk_i);
      u_tester.step(1'b0, 1'b0, b);
      u_tester.scan(1'b0, 32, 64'h0, d);
      check(64'(d[31:0]), 64'(ID_EXP));
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      error_cnt    = 0;
      total_checks = 0;
      rst_b_i      = 1'b0;
      trst_b       = 1'b1;
      pin_in       = 4'h3;
      core_out     = 4'h5;
      core_oe      = 4'h9;
      #3;
      repeat (8) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      t_id_after_reset();
      t_bypass();
      t_pause();
      t_sample();
      t_extest();
      t_tms_reset();
      t_trst();
      print_verdict();
   end

   initial begin
      #1000000;
      error_cnt++;
      print_verdict();
   end
endmodule
